// [hdl/eeh_host.sv]
// ==========================================================================
// Parallel EEPROM host controller
// ==========================================================================
// Purpose : Drives a byte-wide EEPROM: reads, page writes, end-of-write
//           polling and the lock command sequences.
// Assumes : Memory pins are synchronous to ref_clk; one memory attached.
// Notes   : Completion is taken when two polls agree on the toggle bit and, on writes, bit 7 matches the data.
`timescale 1ns/1ps
`include "eeh_params.svh"
module eeh_host
   import eeh_pkg::*;
#(
   parameter int unsigned       POR_CYC  = `EEH_POR_CYC,
   parameter int unsigned       PROG_CYC = `EEH_PROG_CYC,
   parameter logic [14:0]       ENA_A0   = 15'h0001,
   parameter logic [14:0]       ENA_A1   = 15'h0002,
   parameter logic [14:0]       ENA_A2   = 15'h0003,
   parameter logic [7:0]        ENA_D0   = 8'h11,
   parameter logic [7:0]        ENA_D1   = 8'h22,
   parameter logic [7:0]        ENA_D2   = 8'h33,
   parameter logic [14:0]       DIS_A0   = 15'h0004,
   parameter logic [14:0]       DIS_A1   = 15'h0005,
   parameter logic [14:0]       DIS_A2   = 15'h0006,
   parameter logic [7:0]        DIS_D0   = 8'h44,
   parameter logic [7:0]        DIS_D1   = 8'h55,
   parameter logic [7:0]        DIS_D2   = 8'h66
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // User command port
   input  wire logic                cmd_valid,
   output      logic                cmd_ready,
   input  wire logic [1:0]          cmd_op,
   input  wire logic [`EEH_AW-1:0]  cmd_addr,
   input  wire logic [`EEH_DW-1:0]  cmd_wdata,
   input  wire logic                cmd_prefix,
   input  wire logic                cmd_last,
   // User answer port
   output      logic                rsp_valid,
   output      logic [`EEH_DW-1:0]  rsp_data,
   output      logic                busy,
   output      logic                timeout,
   // Memory pins
   output      logic [`EEH_AW-1:0]  mem_addr,
   output      logic                mem_ce_n,
   output      logic                mem_oe_n,
   output      logic                mem_we_n,
   output      logic [`EEH_DW-1:0]  mem_dq_o,
   output      logic                mem_dq_oe,
   input  wire logic [`EEH_DW-1:0]  mem_dq_i
);

   eeh_reg_type r_q;
   eeh_reg_type r_d;
   logic [`EEH_AW-1:0] seq_a;
   logic [`EEH_DW-1:0] seq_d;
   logic               same_pg;

   // ========================================================================
   // Sequence byte select
   // ========================================================================
   // Parameterised lock sequences
   // One selector for the byte just written and the byte about to go out
   function automatic logic [`EEH_AW+`EEH_DW-1:0] seq_byte(
      logic [1:0]         op,
      logic [1:0]         step,
      logic [`EEH_AW-1:0] a,
      logic [`EEH_DW-1:0] d);
      logic [`EEH_AW+`EEH_DW-1:0] res;
      res = {a, d};
      if (step != `EEH_STEP_DATA) begin
         if (op == `EEH_OP_UNLOCK) begin
            unique case (step)
               2'h0:    res = {DIS_A0, DIS_D0};
               2'h1:    res = {DIS_A1, DIS_D1};
               default: res = {DIS_A2, DIS_D2};
            endcase
         end else begin
            unique case (step)
               2'h0:    res = {ENA_A0, ENA_D0};
               2'h1:    res = {ENA_A1, ENA_D1};
               default: res = {ENA_A2, ENA_D2};
            endcase
         end
      end
      return res;
   endfunction

   // Byte of the current step, kept for polling
   assign {seq_a, seq_d} = seq_byte(r_q.op, r_q.step, r_q.addr, r_q.data);

   // Page match for appending a byte to an open page
   assign same_pg = (cmd_addr[`EEH_AW-1:`EEH_PAGE_LSB] == r_q.page);

   // ========================================================================
   // Next state
   // ========================================================================
   always_comb begin
      logic go_exec;
      go_exec = 1'b0;
      r_d = r_q;
      r_d.rsp_valid = 1'b0;
      if (r_q.st != EEH_POR && r_q.st != EEH_IDLE) begin
         r_d.ptmr = r_q.ptmr;
      end
      unique case (r_q.st)
         EEH_POR: begin
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_q.cnt >= `EEH_CW'(POR_CYC - 1)) begin
               r_d.st = EEH_IDLE;
               r_d.ready = 1'b1;
               r_d.busy = 1'b0;
            end
         end
         EEH_IDLE: begin
            // Close page before byte window lapses
            if (r_q.page_open) begin
               r_d.win = r_q.win + 1'b1;
            end
            if (cmd_valid && r_q.ready) begin
               r_d.ready = 1'b0;
               r_d.op = cmd_op;
               r_d.addr = cmd_addr;
               r_d.data = cmd_wdata;
               r_d.pfx = cmd_prefix;
               r_d.last = cmd_last;
               r_d.busy = 1'b1;
               // New page, prefixed write or other command ends the page
               if (r_q.page_open && !(cmd_op == `EEH_OP_WRITE
                   && same_pg && !cmd_prefix)) begin
                  r_d.pend = 1'b1;
                  r_d.st = EEH_POLL;
               end else begin
                  go_exec = 1'b1;
               end
            end else if (r_q.page_open &&
                         r_q.win >= `EEH_WW'(`EEH_WIN_LIM)) begin
               r_d.ready = 1'b0;
               r_d.busy = 1'b1;
               r_d.st = EEH_POLL;
            end
         end
         EEH_WSET: begin
            r_d.st = EEH_WLOW;
            r_d.we_n = 1'b0;
            r_d.cnt = `EEH_CW'(`EEH_WP_CYC - 1);
         end
         // Strobe held far beyond the noise filter
         EEH_WLOW: begin
            r_d.cnt = r_q.cnt - 1'b1;
            if (r_q.cnt == '0) begin
               r_d.we_n = 1'b1;
               r_d.st = EEH_WHI;
            end
         end
         // Data stays driven across strobe rise
         EEH_WHI: begin
            r_d.ce_n = 1'b1;
            r_d.dq_oe = 1'b0;
            if (r_q.step != `EEH_STEP_DATA && (r_q.step != `EEH_STEP_LAST
                || (r_q.op == `EEH_OP_WRITE))) begin
               // Prefix bytes at page write pace
               r_d.step = (r_q.step == `EEH_STEP_LAST) ?
                          `EEH_STEP_DATA : r_q.step + 1'b1;
               r_d.st = EEH_WSET;
            end else begin
               r_d.paddr = seq_a;
               r_d.pdata = seq_d;
               // Sequence bytes are not compared on polls
               r_d.chk7 = (r_q.op == `EEH_OP_WRITE);
               if (r_q.op == `EEH_OP_WRITE && !r_q.last) begin
                  // Keep page open for more bytes
                  r_d.page_open = 1'b1;
                  r_d.page = r_q.addr[`EEH_AW-1:`EEH_PAGE_LSB];
                  r_d.win = '0;
                  r_d.st = EEH_IDLE;
                  r_d.ready = 1'b1;
               end else begin
                  r_d.st = EEH_POLL;
               end
            end
            if (r_q.step == `EEH_STEP_LAST && r_q.op != `EEH_OP_WRITE) begin
               r_d.page_open = 1'b0;
            end
         end
         // Status polling of the last byte written
         EEH_POLL: begin
            r_d.polling = 1'b1;
            r_d.page_open = 1'b0;
            r_d.a = r_q.paddr;
            r_d.st = EEH_RSET;
         end
         EEH_RSET: begin
            r_d.st = EEH_RWAIT;
            r_d.cnt = `EEH_CW'(`EEH_RD_CYC - 1);
         end
         EEH_RWAIT: begin
            r_d.cnt = r_q.cnt - 1'b1;
            if (r_q.cnt == '0) begin
               // Release enables so memory floats the bus
               r_d.ce_n = 1'b1;
               r_d.oe_n = 1'b1;
               if (!r_q.polling) begin
                  r_d.rsp_valid = 1'b1;
                  r_d.rsp_data = mem_dq_i;
                  r_d.busy = 1'b0;
                  r_d.ready = 1'b1;
                  r_d.st = EEH_IDLE;
               end else begin
                  r_d.tog = mem_dq_i[`EEH_TOG_BIT];
                  r_d.have = 1'b1;
                  // Gap cycle so each poll is a fresh read edge
                  r_d.st = EEH_POLL;
                  // Toggle stopped and true data seen
                  if ((r_q.have && r_q.tog == mem_dq_i[`EEH_TOG_BIT] &&
                      (!r_q.chk7 || mem_dq_i[`EEH_POLL_BIT] ==
                       r_q.pdata[`EEH_POLL_BIT])) ||
                      // Give up past worst-case program time
                      r_q.ptmr >= `EEH_CW'(PROG_CYC)) begin
                     r_d.timeout = r_q.timeout |
                                   (r_q.ptmr >= `EEH_CW'(PROG_CYC));
                     r_d.polling = 1'b0;
                     r_d.have = 1'b0;
                     r_d.ptmr = '0;
                     r_d.pend = 1'b0;
                     r_d.busy = r_q.pend;
                     r_d.ready = !r_q.pend;
                     r_d.st = EEH_IDLE;
                     go_exec = r_q.pend;
                  end
               end
            end
         end
      endcase
      // Poll timer runs while polling; separate from cycle counter
      if (r_q.polling && r_d.polling) begin
         r_d.ptmr = r_q.ptmr + 1'b1;
      end
      // Writes only with output enable high, reads with strobe high
      if (go_exec) begin
         if (r_d.op == `EEH_OP_READ) begin
            r_d.a = r_d.addr;
            r_d.ce_n = 1'b0;
            r_d.oe_n = 1'b0;
            r_d.st = EEH_RSET;
         end else begin
            // Lock and unlock are three-byte writes
            r_d.step = (r_d.op == `EEH_OP_WRITE && !r_d.pfx) ?
                       `EEH_STEP_DATA : 2'h0;
            r_d.st = EEH_WSET;
            r_d.oe_n = 1'b1;
            r_d.ce_n = 1'b0;
            r_d.dq_oe = 1'b1;
         end
      end
      // Address and data set ahead of strobe fall
      if (r_d.st == EEH_WSET) begin
         r_d.ce_n = 1'b0;
         r_d.dq_oe = 1'b1;
         {r_d.a, r_d.dq_o} = seq_byte(r_d.op, r_d.step, r_d.addr, r_d.data);
      end
      if (r_d.st == EEH_RSET) begin
         r_d.ce_n = 1'b0;
         r_d.oe_n = 1'b0;
      end
   end

   // ========================================================================
   // State register; reset values are constants only
   // ========================================================================
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '0;
         r_q.st <= EEH_POR;
         r_q.ce_n <= 1'b1;
         r_q.oe_n <= 1'b1;
         r_q.we_n <= 1'b1;
         r_q.busy <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state record
   assign cmd_ready = r_q.ready;
   assign rsp_valid = r_q.rsp_valid;
   assign rsp_data  = r_q.rsp_data;
   assign busy      = r_q.busy;
   assign timeout   = r_q.timeout;
   assign mem_addr  = r_q.a;
   assign mem_ce_n  = r_q.ce_n;
   assign mem_oe_n  = r_q.oe_n;
   assign mem_we_n  = r_q.we_n;
   assign mem_dq_o  = r_q.dq_o;
   assign mem_dq_oe = r_q.dq_oe;

   // ========================================================================
   // Assertions
   // ========================================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_strobe_enables: assert property (
      !mem_we_n |-> !mem_ce_n && mem_oe_n)
      else $error("strobe low without chip enable or with output enable");
   a_no_inhibit_write: assert property (
      !(mem_we_n == 1'b0 && mem_oe_n == 1'b0))
      else $error("strobe and output enable low together");
   a_bus_no_fight: assert property (
      mem_dq_oe |-> mem_oe_n)
      else $error("host drives data while memory may drive");
   a_pulse_width: assert property (
      $fell(mem_we_n) |-> !mem_we_n ##1 mem_we_n ##1 mem_we_n)
      else $error("write pulse shape wrong");
   a_addr_stable: assert property (
      $fell(mem_we_n) |=> $stable(mem_addr) && $stable(mem_dq_o))
      else $error("address or data moved under strobe");
   a_data_at_rise: assert property (
      $rose(mem_we_n) |-> mem_dq_oe && !mem_ce_n)
      else $error("data not driven at strobe rise");
   a_por_no_write: assert property (
      r_q.st == EEH_POR |-> mem_we_n && !cmd_ready)
      else $error("activity during power-on delay");
   a_page_same: assert property (
      $fell(mem_we_n) && r_q.page_open |->
      mem_addr[`EEH_AW-1:`EEH_PAGE_LSB] == r_q.page)
      else $error("page changed inside a page write");
   a_win_bound: assert property (
      r_q.page_open |-> r_q.win <= `EEH_WW'(`EEH_WIN_LIM + 1))
      else $error("byte load window overrun");
   a_poll_bound: assert property (
      r_q.ptmr <= `EEH_CW'(PROG_CYC + `EEH_RD_CYC + 2))
      else $error("poll ran past program time");

   c_read_done:  cover property (rsp_valid);
   c_page_open:  cover property ($rose(r_q.page_open));
   c_poll_done:  cover property ($fell(r_q.polling) && !timeout);
   c_lock_seq:   cover property (r_q.op == `EEH_OP_LOCK && $rose(mem_we_n));

endmodule

// [shared/eeh_params.svh]
// ==========================================================================
// Parallel EEPROM host: constants
// ==========================================================================
// Purpose : Named timing, field and command constants for the host.
// Assumes : 10 MHz ref_clk, 32K x 8 memory with 64-byte pages.
// Notes   : Times are in ns, the load margin in cycles; cycle counts are derived from them.
//
// Functional notes
// - Write starts by strobe low pulse with chip enable low, output high.
// - Page write: first byte plus up to 63 more, 64 programmed together.
// - Next page byte within 150 us, else memory starts programming.
// - Host keeps page select lines equal for every strobe fall in a page.
// - Lock off as delivered; three-byte sequence turns it on.
// - While locked, writes preceded by the enable sequence still proceed.
// - Host issues lock sequences with page write byte timing.
`ifndef EEH_PARAMS_SVH
`define EEH_PARAMS_SVH

// Bus geometry
`define EEH_AW          15
`define EEH_DW          8
`define EEH_PAGE_LSB    6
`define EEH_POLL_BIT    7
`define EEH_TOG_BIT     6

// Command opcodes on the user port
`define EEH_OP_READ     2'h0
`define EEH_OP_WRITE    2'h1
`define EEH_OP_LOCK     2'h2
`define EEH_OP_UNLOCK   2'h3

// Sequence steps; step three carries user data
`define EEH_STEP_LAST   2'h2
`define EEH_STEP_DATA   2'h3

// Timing in ns; load margin in cycles
`define EEH_CLK_NS      100
`define EEH_T_WP_NS     100
`define EEH_T_ACC_NS    120
`define EEH_T_POR_NS    5000000
`define EEH_T_PROG_NS   10000000
`define EEH_T_LOAD_NS   150000
`define EEH_LOAD_MARGIN 100

// Derived cycle counts (least times and program time round up, load window rounds down)
`define EEH_WP_CYC   ((`EEH_T_WP_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_RD_CYC   ((`EEH_T_ACC_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_POR_CYC  ((`EEH_T_POR_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_PROG_CYC ((`EEH_T_PROG_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_LOAD_CYC (`EEH_T_LOAD_NS / `EEH_CLK_NS)
`define EEH_WIN_LIM  (`EEH_LOAD_CYC - `EEH_LOAD_MARGIN)

// Counter widths
`define EEH_CW       17
`define EEH_WW       11

`endif

// [shared/eeh_pkg.sv]
// ==========================================================================
// Parallel EEPROM host: types
// ==========================================================================
// Purpose : State enumeration and the packed state record.
// Assumes : eeh_params.svh supplies the bus, page and counter widths.
// Notes   : One record holds every flip-flop of the host.
`include "eeh_params.svh"
package eeh_pkg;

   typedef enum logic [3:0] {
      EEH_POR, EEH_IDLE, EEH_WSET, EEH_WLOW, EEH_WHI,
      EEH_RSET, EEH_RWAIT, EEH_POLL
   } eeh_state_type;

   typedef struct packed {
      eeh_state_type             st;
      logic [`EEH_CW-1:0]        cnt;
      logic [`EEH_CW-1:0]        ptmr;
      logic [`EEH_WW-1:0]        win;
      logic [1:0]                step;
      logic [1:0]                op;
      logic                      pfx;
      logic                      last;
      logic                      pend;
      logic                      polling;
      logic                      chk7;
      logic                      tog;
      logic                      have;
      logic                      page_open;
      logic [`EEH_AW-1:0]        addr;
      logic [`EEH_DW-1:0]        data;
      logic [`EEH_AW-1:0]        paddr;
      logic [`EEH_DW-1:0]        pdata;
      logic [`EEH_AW-`EEH_PAGE_LSB-1:0] page;
      logic [`EEH_AW-1:0]        a;
      logic                      ce_n;
      logic                      oe_n;
      logic                      we_n;
      logic [`EEH_DW-1:0]        dq_o;
      logic                      dq_oe;
      logic                      ready;
      logic                      rsp_valid;
      logic [`EEH_DW-1:0]        rsp_data;
      logic                      busy;
      logic                      timeout;
   } eeh_reg_type;

endpackage

// [testbench/eeh_mem_model.sv]
// ==========================================================================
// Parallel EEPROM behavioural memory
// ==========================================================================
// Purpose : Byte-wide EEPROM seen on the host's pins.
// Assumes : ref_clk only paces the load window and programming.
// Notes   : Busy from first load until programmed; idle bus reads inverted.
`timescale 1ns/1ps
module eeh_mem_model
   import eeh_pkg::*;
#(
   parameter int                LOAD_CYC = 1500,
   parameter int                POR_NS   = 1000,
   parameter logic [2:0][22:0]  ENA = {23'h000333, 23'h000222, 23'h000111},
   parameter logic [2:0][22:0]  DIS = {23'h000666, 23'h000555, 23'h000444}
) (
   // Timing
   input  wire logic        ref_clk,
   input  wire logic [15:0] prog_cyc,
   // Host pins
   input  wire logic [14:0] mem_addr,
   input  wire logic        mem_ce_n,
   input  wire logic        mem_oe_n,
   input  wire logic        mem_we_n,
   input  wire logic [7:0]  mem_dq_o,
   output      logic [7:0]  mem_dq_i
);
   logic [7:0]  mem [32768];
   logic [7:0]  pbuf [64];
   logic [7:0]  val, held, lastd;
   logic [63:0] mask;
   logic [14:0] la;
   logic [8:0]  page;
   logic        loading, prog, tog, lock, pfx, se, sd;
   int          lc, pc, n;
   realtime     t0;
   wire wsel = ~mem_ce_n & ~mem_we_n & mem_oe_n;
   wire rd   = ~mem_ce_n & ~mem_oe_n & mem_we_n;

   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'ha5;
      {loading, prog, tog, lock, pfx, held, mask} = '0;
   end
   always @(posedge wsel) begin
      la = mem_addr;
      t0 = $realtime;
   end
   always @(negedge wsel) if ($realtime - t0 >= 15 && $realtime >= POR_NS
                              && !prog) begin
      if (!loading) begin
         {mask, n, se, sd, pfx} = {64'h0, 32'h0, 3'b110};
      end
      page = la[14:6];
      pbuf[la[5:0]] = mem_dq_o;
      mask[la[5:0]] = 1'b1;
      lastd = mem_dq_o;
      {loading, lc} = {1'b1, 32'h0};
      if (n < 3) begin
         se &= {la, mem_dq_o} == ENA[n];
         sd &= {la, mem_dq_o} == DIS[n];
      end
      n++;
      if (n == 3 && (se || sd)) begin
         {mask, pfx, lock} = {64'h0, 1'b1, se};
      end
   end
   always @(posedge ref_clk) begin
      if (loading) begin
         if (lc >= LOAD_CYC) {loading, prog, pc} = {2'b01, 32'h0};
         else lc++;
      end else if (prog) begin
         if (pc >= prog_cyc) begin
            prog = 0;
            for (int i = 0; i < 64; i++)
               if (mask[i] && (pfx || !lock)) mem[{page, i[5:0]}] = pbuf[i];
         end else pc++;
      end
   end
   always @(posedge rd) if (loading || prog) tog = ~tog;
   assign val = (loading || prog) ? {~lastd[7], tog, lastd[5:0]}
                                  : mem[mem_addr];
   always @(negedge rd) held = val;
   // released bus shows no stale value
   assign mem_dq_i = rd ? val : ~held;
endmodule

// [testbench/tb_top.sv]
// ==========================================================================
// Parallel EEPROM host testbench
// ==========================================================================
// Purpose : Self-checking run of the host against the memory model.
// Assumes : Short power-on and programming counts for simulation.
// Notes   : Random values from a 16-bit LFSR seeded at 52207.
`timescale 1ns/1ps
module tb_top;
   import eeh_pkg::*;
   localparam int POR = 20;
   localparam int PROG = 2000;
   logic        ref_clk, rst_n, cmd_valid, cmd_ready, cmd_prefix, cmd_last;
   logic [1:0]  cmd_op;
   logic [14:0] cmd_addr, mem_addr, a, pg;
   logic [7:0]  cmd_wdata, rsp_data, mem_dq_o, mem_dq_i, d, got;
   logic        rsp_valid, busy, timeout, mem_ce_n, mem_oe_n, mem_we_n;
   logic        mem_dq_oe;
   logic [15:0] prog_cyc, rnd;
   logic [7:0]  shadow [int];
   int          n_mismatch = 0;
   int          num_checks = 0;

   eeh_host #(.POR_CYC(POR), .PROG_CYC(PROG)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_prefix(cmd_prefix), .cmd_last(cmd_last),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
      .timeout(timeout), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
      .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o),
      .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
   eeh_mem_model i_mem (
      .ref_clk(ref_clk), .prog_cyc(prog_cyc), .mem_addr(mem_addr),
      .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
      .mem_dq_o(mem_dq_o), .mem_dq_i(mem_dq_i));

   // ========================================================================
   // Helpers
   // ========================================================================
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0);
   endfunction
   // Unwritten bytes keep the model's fill pattern
   function automatic logic [7:0] expect_at(logic [14:0] x);
      return shadow.exists(x) ? shadow[x] : x[7:0] ^ 8'ha5;
   endfunction
   // Request held until the edge that sees cmd_ready
   task automatic issue(logic [1:0] op, logic [14:0] x, logic [7:0] v,
                        logic p, logic l);
      int k;
      k = 0;
      @(posedge ref_clk);
      #1 {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, op, x, v};
      {cmd_prefix, cmd_last} = {p, l};
      do begin
         @(posedge ref_clk);
         k++;
      end while (cmd_ready !== 1'b1 && k < PROG * 3);
      if (k >= PROG * 3) n_mismatch++;
      #1 cmd_valid = 0;
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while ((cmd_ready !== 1'b1 || busy !== 1'b0) && k < PROG * 3) begin
         @(posedge ref_clk);
         #1 k++;
      end
      if (k >= PROG * 3) n_mismatch++;
   endtask
   task automatic wr(logic [14:0] x, logic [7:0] v, logic p, logic l,
                     logic st);
      issue(2'h1, x, v, p, l);
      if (st) shadow[x] = v;
   endtask
   task automatic rd_chk(logic [14:0] x);
      int k;
      k = 0;
      issue(2'h0, x, 8'h0, 1'b0, 1'b0);
      while (rsp_valid !== 1'b1 && k < PROG * 3) begin
         @(posedge ref_clk);
         #1 k++;
      end
      if (k >= PROG * 3) n_mismatch++;
      check("read data", rsp_data, expect_at(x));
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ========================================================================
   // Clock, watchdog, bus monitor
   // ========================================================================
   initial begin
      ref_clk = 0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      report_and_stop();
   end
   // Host must never fight the memory's outputs
   always @(posedge ref_clk) if (rst_n && mem_dq_oe === 1'b1)
      check("oe_n while driving", {7'h0, mem_oe_n}, 8'h1);

   // ========================================================================
   // Scenarios
   // ========================================================================
   initial begin
      {rst_n, cmd_valid, cmd_op, cmd_addr, cmd_wdata} = '0;
      {cmd_prefix, cmd_last, prog_cyc, rnd} = {2'b00, 16'd100, 16'd52207};
      repeat (8) @(posedge ref_clk);
      check("busy in reset", {7'h0, busy}, 8'h1);
      #1 rst_n = 1;
      repeat (POR - 2) @(posedge ref_clk);
      check("ready in power-on", {7'h0, cmd_ready}, 8'h0);
      wait_idle();
      // Random bytes, with all-zero and all-one corners
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         a = rnd[14:0];
         rnd = lfsr(rnd);
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
         wr(a, d, 0, 1, 1);
         rd_chk(a);
      end
      // Page load out of order, overwrite; a read closes the page
      rnd = lfsr(rnd);
      pg = {rnd[8:0], 6'h0};
      wr(pg + 5, 8'h3c, 0, 0, 1);
      wr(pg, 8'h81, 0, 0, 1);
      wr(pg + 63, 8'h7e, 0, 0, 1);
      wr(pg + 5, 8'hc3, 0, 0, 1);
      for (int i = 0; i < 4; i++) rd_chk(pg + i);
      rd_chk(pg + 63);
      // Page closed by idle time alone
      wr(pg + 9, 8'h5e, 0, 0, 1);
      repeat (1500) @(posedge ref_clk);
      rd_chk(pg + 9);
      // Lock, locked writes, unlock
      wr(15'h0001, 8'h5a, 0, 1, 1);
      issue(2'h2, 15'h0, 8'h0, 0, 0);
      a = 15'h0100;
      d = expect_at(a) ^ 8'h01;
      wr(a, d, 0, 1, 0);
      rd_chk(a);
      wr(a, 8'h96, 1, 1, 1);
      rd_chk(a);
      rd_chk(15'h0001);
      rd_chk(15'h0002);
      issue(2'h3, 15'h0, 8'h0, 0, 0);
      wr(a, 8'h24, 0, 1, 1);
      rd_chk(a);
      // Memory slower than the host's poll limit
      check("timeout early", {7'h0, timeout}, 8'h0);
      prog_cyc = 16'd3000;
      wr(15'h2345, 8'h11, 0, 1, 0);
      wait_idle();
      check("timeout late", {7'h0, timeout}, 8'h1);
      report_and_stop();
   end
endmodule
